// ==== hdl/teattr_pkg.sv ====
// shared constants and carrier types for the translation entry attribute store
// assumes a single core clock and a pipeline that issues special register moves
package teattr_pkg;

  // special register selectors
  localparam logic [15:0] SEL_XLATE_LOW = 16'h1003;
  localparam logic [15:0] SEL_XLATE_HIGH = 16'h1004;

  // buffer geometry
  localparam int unsigned ENTRY_COUNT = 64;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned IDX_LSB = 0;
  localparam int unsigned OWNER_W = 8;
  localparam int unsigned TAG_W = 22;

  // reset values on configuration download
  localparam logic [31:0] XLATE_HIGH_RST = 32'h0000_0000;
  localparam logic [31:0] XLATE_LOW_RST = 32'h0000_0000;
  localparam logic [7:0] OWNER_RST = 8'h00;

  // low word field positions, bit 0 is the least significant
  localparam int unsigned LO_FETCH_PERMIT = 9;
  localparam int unsigned LO_WRITABLE = 8;
  localparam int unsigned LO_ZONE_PICK_LSB = 4;
  localparam int unsigned LO_WRITE_THRU = 3;
  localparam int unsigned LO_CACHE_INH = 2;
  localparam int unsigned LO_COHERENT = 1;
  localparam int unsigned LO_GUARDED = 0;

  // high word field positions
  localparam int unsigned HI_TAG_LSB = 10;
  localparam int unsigned HI_SIZE_LSB = 7;
  localparam int unsigned HI_VALID = 6;
  localparam int unsigned HI_BYTE_ORDER = 5;
  localparam int unsigned HI_USER_ATTR = 4;

  // writable bits of each word
  localparam logic [31:0] LO_WR_MASK = 32'h0000_03FD;
  localparam logic [31:0] HI_WR_MASK_BASE = 32'hFFFF_FFC0;

  // zone override codes
  localparam logic [1:0] ZONE_DENY = 2'h0;
  localparam logic [1:0] ZONE_GRANT = 2'h3;

  // configuration thresholds
  localparam int unsigned MMU_LEVEL_MIN = 1;
  localparam int unsigned ACCESS_READ_MIN = 2;

  typedef enum logic [1:0] {
    TEATTR_KIND_LOAD = 2'h0,
    TEATTR_KIND_STORE = 2'h1,
    TEATTR_KIND_FETCH = 2'h2,
    TEATTR_KIND_SPEC = 2'h3
  } teattr_kind_t;

  typedef struct packed {
    logic [15:0] sel;
    logic move_to_special;
    logic move_from_special;
    logic [31:0] wdata;
  } teattr_sreg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } teattr_sreg_rsp_t;

  typedef struct packed {
    logic valid;
    teattr_kind_t kind;
    logic [IDX_W-1:0] idx;
    logic [31:0] vaddr;
  } teattr_chk_req_t;

  typedef struct packed {
    logic done;
    logic hit;
    logic go;
    logic data_excp;
    logic fetch_excp;
    logic spec_block;
    logic cacheable;
    logic write_thru;
    logic guarded;
    logic little_end;
  } teattr_chk_rsp_t;

endpackage : teattr_pkg

// ==== hdl/teattr_check.sv ====
// combinational permission and attribute evaluation of one buffer entry
// assumes entry words arrive already masked and with fixed bits applied
module teattr_check
  import teattr_pkg::*;
#(
  parameter bit DEFAULT_LITTLE = 1'b0
) (
  input wire logic [31:0] i_lo,
  input wire logic [31:0] i_hi,
  input wire logic i_user_mode,
  input wire logic [31:0] i_zone_override,
  input wire teattr_chk_req_t i_req,
  output teattr_chk_rsp_t o_rsp
);

  // one two-bit field, zone 0 in the top bits
  function automatic logic [1:0] zone_field(input logic [31:0] zreg, input logic [3:0] n);
    logic [31:0] s;
    s = zreg << {n, 1'b0};
    return s[31:30];
  endfunction

  // two tag bits drop out per size step
  function automatic logic [TAG_W-1:0] size_mask(input logic [2:0] size);
    return 22'h3F_FFFF << {size, 1'b0};
  endfunction

  logic [1:0] zone;
  logic grant_all;
  logic valid_eff;
  logic tag_match;
  logic may_write;
  logic may_fetch;
  logic [TAG_W-1:0] msk;

  always_comb begin
    zone = zone_field(i_zone_override, i_lo[LO_ZONE_PICK_LSB +: 4]);
    grant_all = i_user_mode ? (zone == ZONE_GRANT) : zone[1];
    valid_eff = i_hi[HI_VALID] & ~(i_user_mode & (zone == ZONE_DENY));
    msk = size_mask(i_hi[HI_SIZE_LSB +: 3]);
    tag_match = ((i_hi[31:HI_TAG_LSB] ^ i_req.vaddr[31:HI_TAG_LSB]) & msk) == '0;
    may_write = i_lo[LO_WRITABLE] | grant_all;
    may_fetch = i_lo[LO_FETCH_PERMIT] | grant_all;

    o_rsp = '0;
    o_rsp.done = i_req.valid;
    o_rsp.hit = i_req.valid & valid_eff & tag_match;
    o_rsp.data_excp = o_rsp.hit & (i_req.kind == TEATTR_KIND_STORE) & ~may_write;
    o_rsp.fetch_excp = o_rsp.hit & (i_req.kind == TEATTR_KIND_FETCH) & ~may_fetch;
    o_rsp.spec_block = o_rsp.hit & (i_req.kind == TEATTR_KIND_SPEC) & i_lo[LO_GUARDED];
    o_rsp.go = o_rsp.hit & ~o_rsp.data_excp & ~o_rsp.fetch_excp & ~o_rsp.spec_block;
    o_rsp.cacheable = ~i_lo[LO_CACHE_INH];
    o_rsp.write_thru = i_lo[LO_WRITE_THRU];
    o_rsp.guarded = i_lo[LO_GUARDED];
    if (i_req.kind == TEATTR_KIND_FETCH) begin
      o_rsp.little_end = DEFAULT_LITTLE;
    end else begin
      o_rsp.little_end = DEFAULT_LITTLE ^ i_hi[HI_BYTE_ORDER];
    end
    // idle cycles give a quiet result, so stale attributes never leak
    if (!i_req.valid) begin
      o_rsp = '0;
    end
  end

endmodule // teattr_check

// ==== hdl/teattr_top.sv ====
// unified translation buffer entry store with low and high attribute words
// assumes the pipeline gives index, zone and process tag registers as inputs
// and uses a check result's go bit before letting any access take effect
module teattr_top
  import teattr_pkg::*;
#(
  parameter int unsigned MMU_LEVEL_PARAM = 3,
  parameter bit AREA_SAVING_PARAM = 1'b0,
  parameter int unsigned XLATE_ACCESS_LEVEL = 3,
  parameter bit DCACHE_WRITEBACK_OPTION = 1'b1,
  parameter bit BYTE_REVERSAL_OPTION = 1'b1,
  parameter bit DEFAULT_LITTLE = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_cfg_load,
  input wire logic i_user_mode,
  input wire teattr_sreg_req_t i_sreg,
  input wire logic [7:0] i_proc_tag,
  input wire logic [31:0] i_zone_override,
  input wire logic [31:0] i_xlate_index,
  input wire teattr_chk_req_t i_chk,
  output teattr_sreg_rsp_t o_sreg_rsp,
  output logic o_proc_tag_load,
  output logic [7:0] o_proc_tag_val,
  output teattr_chk_rsp_t o_chk_rsp
);

  localparam bit IMPL = (MMU_LEVEL_PARAM > MMU_LEVEL_MIN) && !AREA_SAVING_PARAM;
  localparam bit READ_OK = IMPL && (XLATE_ACCESS_LEVEL >= ACCESS_READ_MIN);

  typedef struct packed {
    logic [ENTRY_COUNT-1:0][31:0] lo;
    logic [ENTRY_COUNT-1:0][31:0] hi;
    logic [ENTRY_COUNT-1:0][OWNER_W-1:0] owner;
    teattr_sreg_rsp_t rsp;
    logic tag_load;
    logic [7:0] tag_val;
    teattr_chk_rsp_t chk;
  } teattr_state_t;

  teattr_state_t st_r;
  teattr_state_t st_nxt;

  // stored bits of the low word; coherence and page number never stored
  function automatic logic [31:0] lo_store(input logic [31:0] w);
    return w & LO_WR_MASK;
  endfunction

  // fixed bits applied on every use, so download state needs no option test
  function automatic logic [31:0] lo_view(input logic [31:0] w);
    logic [31:0] v;
    v = w & LO_WR_MASK;
    v[LO_COHERENT] = 1'b0;
    if (!DCACHE_WRITEBACK_OPTION) begin
      v[LO_WRITE_THRU] = 1'b1;
    end
    return v;
  endfunction

  function automatic logic [31:0] hi_mask();
    logic [31:0] m;
    m = HI_WR_MASK_BASE;
    m[HI_BYTE_ORDER] = BYTE_REVERSAL_OPTION;
    m[HI_USER_ATTR] = 1'b0;
    return m;
  endfunction

  function automatic logic [31:0] hi_view(input logic [31:0] w);
    return w & hi_mask();
  endfunction

  logic [IDX_W-1:0] acc_idx;
  logic sel_lo;
  logic sel_hi;
  logic [31:0] chk_lo;
  logic [31:0] chk_hi;
  teattr_chk_rsp_t chk_now;

  assign acc_idx = i_xlate_index[IDX_LSB +: IDX_W];
  assign sel_lo = IMPL && (i_sreg.sel == SEL_XLATE_LOW);
  assign sel_hi = IMPL && (i_sreg.sel == SEL_XLATE_HIGH);

  assign chk_lo = lo_view(st_r.lo[i_chk.idx]);
  assign chk_hi = hi_view(st_r.hi[i_chk.idx]);

  teattr_check #(
    .DEFAULT_LITTLE(DEFAULT_LITTLE)
  ) u_check (
    .i_lo(chk_lo),
    .i_hi(chk_hi),
    .i_user_mode(i_user_mode),
    .i_zone_override(i_zone_override),
    .i_req(i_chk),
    .o_rsp(chk_now)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    st_nxt.tag_load = 1'b0;
    st_nxt.chk = '0;

    if (i_sreg.move_to_special && sel_lo) begin
      st_nxt.lo[acc_idx] = lo_store(i_sreg.wdata);
    end
    if (i_sreg.move_to_special && sel_hi) begin
      st_nxt.hi[acc_idx] = i_sreg.wdata & hi_mask();
      st_nxt.owner[acc_idx] = i_proc_tag;
    end

    if (i_sreg.move_from_special && READ_OK && sel_lo) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.data = lo_view(st_r.lo[acc_idx]);
    end
    if (i_sreg.move_from_special && READ_OK && sel_hi) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.data = hi_view(st_r.hi[acc_idx]);
      if (!i_user_mode) begin
        st_nxt.tag_load = 1'b1;
        st_nxt.tag_val = st_r.owner[acc_idx];
      end
    end

    if (IMPL) begin
      st_nxt.chk = chk_now;
    end

    if (i_srst) begin
      st_nxt.rsp = '0;
      st_nxt.tag_load = 1'b0;
      st_nxt.tag_val = OWNER_RST;
      st_nxt.chk = '0;
    end

    if (i_cfg_load) begin
      for (int i = 0; i < ENTRY_COUNT; i++) begin
        st_nxt.lo[i] = XLATE_LOW_RST;
        st_nxt.hi[i] = XLATE_HIGH_RST;
        st_nxt.owner[i] = OWNER_RST;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_r <= st_nxt;
  end

  assign o_sreg_rsp = st_r.rsp;
  assign o_proc_tag_load = st_r.tag_load;
  assign o_proc_tag_val = st_r.tag_val;
  assign o_chk_rsp = st_r.chk;

endmodule // teattr_top

// ==== testbench/teattr_asserts.sv ====
// port assertions for the translation entry store
// bound to teattr_top, sees only its ports
module teattr_asserts
  import teattr_pkg::*;
#(
  parameter bit DEFAULT_LITTLE = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_cfg_load,
  input wire logic i_user_mode,
  input wire teattr_sreg_req_t i_sreg,
  input wire logic [7:0] i_proc_tag,
  input wire logic [31:0] i_zone_override,
  input wire logic [31:0] i_xlate_index,
  input wire teattr_chk_req_t i_chk,
  input wire teattr_sreg_rsp_t o_sreg_rsp,
  input wire logic o_proc_tag_load,
  input wire logic [7:0] o_proc_tag_val,
  input wire teattr_chk_rsp_t o_chk_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_rd_hi;
    i_sreg.move_from_special && i_sreg.sel == SEL_XLATE_HIGH;
  endsequence
  rd_answer_a: assert property (s_rd_hi |=> o_sreg_rsp.valid)
    else $error("high word read gave no answer");
  tag_load_a: assert property (s_rd_hi ##0 !i_user_mode |=> o_proc_tag_load)
    else $error("privileged high read did not load the process tag");
  chk_done_a: assert property (i_chk.valid |=> o_chk_rsp.done)
    else $error("check request gave no result");
  excp_no_go_a: assert property ((o_chk_rsp.data_excp || o_chk_rsp.fetch_excp) |->
    !o_chk_rsp.go) else $error("faulting access allowed to proceed");
  coherent_zero_a: assert property (o_sreg_rsp.valid |-> !o_sreg_rsp.data[LO_COHERENT])
    else $error("coherence bit read as one");
  user_attr_a: assert property (s_rd_hi |=> o_sreg_rsp.data[4:0] == 5'h00)
    else $error("fixed high bits read nonzero");
  fetch_order_a: assert property (i_chk.valid && i_chk.kind == TEATTR_KIND_FETCH |=>
    o_chk_rsp.little_end == DEFAULT_LITTLE) else $error("fetch byte order changed");
  spec_guard_a: assert property (o_chk_rsp.spec_block |->
    !o_chk_rsp.go && o_chk_rsp.guarded) else $error("speculative block on unguarded page");
endmodule // teattr_asserts

// ==== testbench/teattr_pipe_model.sv ====
// process tag register of the pipeline, far side of the store
// bench sets it, the store reloads it through the load pulse
module teattr_pipe_model (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_set,
  input wire logic [7:0] i_set_val,
  input wire logic i_load,
  input wire logic [7:0] i_load_val,
  output logic [7:0] o_proc_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_proc_tag <= 8'h00;
    end else if (i_load) begin
      o_proc_tag <= i_load_val;
    end else if (i_set) begin
      o_proc_tag <= i_set_val;
    end
  end
endmodule // teattr_pipe_model

// ==== testbench/teattr_tb.sv ====
// self-checking bench for the translation entry store
// drives inputs on the falling edge, outputs checked a cycle later
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module teattr_tb;
  import teattr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cfg = 1'b1, um = 1'b0, set = 1'b0;
  logic [7:0] set_val = 8'h00, ptag, tag_val;
  logic [31:0] zone = 32'h0, xidx = 32'h0;
  logic tag_load;
  teattr_sreg_req_t sreg = '0;
  teattr_chk_req_t chk = '0;
  teattr_sreg_rsp_t rsp;
  teattr_chk_rsp_t cr;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #2 clk = ~clk;
  teattr_top i_dut (.i_ref_clk(clk), .i_srst(srst), .i_cfg_load(cfg), .i_user_mode(um),
    .i_sreg(sreg), .i_proc_tag(ptag), .i_zone_override(zone), .i_xlate_index(xidx),
    .i_chk(chk), .o_sreg_rsp(rsp), .o_proc_tag_load(tag_load), .o_proc_tag_val(tag_val),
    .o_chk_rsp(cr));
  teattr_pipe_model i_pipe (.i_ref_clk(clk), .i_srst(srst), .i_set(set), .i_set_val(set_val),
    .i_load(tag_load), .i_load_val(tag_val), .o_proc_tag(ptag));
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, tests need under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic sreg_op(input logic wr, input logic [15:0] sel, input logic [5:0] idx,
    input logic [31:0] wd);
    @(negedge clk);
    sreg = '{sel: sel, move_to_special: wr, move_from_special: !wr, wdata: wd};
    xidx = {26'h0, idx};
    @(negedge clk);
    sreg = '0;
  endtask
  task automatic chk_op(input teattr_kind_t k, input logic [5:0] idx, input logic [31:0] va);
    @(negedge clk);
    chk = '{valid: 1'b1, kind: k, idx: idx, vaddr: va};
    @(negedge clk);
    chk = '0;
  endtask
  task automatic t_regs();
    sreg_op(1'b0, SEL_XLATE_HIGH, 6'h04, 32'h0);
    `CHK("hi4", 32'h0000_0000, rsp.data)
    set = 1'b1;
    set_val = 8'hAB;
    sreg_op(1'b1, SEL_XLATE_LOW, 6'h03, 32'hFFFF_FFFF);
    set = 1'b0;
    sreg_op(1'b1, SEL_XLATE_HIGH, 6'h03, 32'hFFFF_FFFF);
    sreg_op(1'b1, SEL_XLATE_LOW, 6'h04, 32'h0000_0050);
    sreg_op(1'b1, SEL_XLATE_HIGH, 6'h04, 32'h0000_0040);
    sreg_op(1'b0, SEL_XLATE_LOW, 6'h03, 32'h0);
    `CHK("lo3", 32'h0000_03FD, rsp.data)
    set = 1'b1;
    set_val = 8'h5C;
    sreg_op(1'b0, SEL_XLATE_HIGH, 6'h03, 32'h0);
    set = 1'b0;
    `CHK("hi3", 32'hFFFF_FFE0, rsp.data)
    `CHK("owner", 8'hAB, tag_val)
    @(negedge clk);
    `CHK("ptag", 8'hAB, ptag)
    um = 1'b1;
    sreg_op(1'b0, SEL_XLATE_HIGH, 6'h04, 32'h0);
    `CHK("hi4", {1'b1, 32'h0000_0040}, {rsp.valid, rsp.data})
    `CHK("uload", 1'b0, tag_load)
    um = 1'b0;
    sreg_op(1'b0, 16'h1005, 6'h04, 32'h0);
    `CHK("bad sel", 1'b0, rsp.valid)
  endtask
  task automatic t_perm();
    chk_op(TEATTR_KIND_STORE, 6'h03, 32'hFFFF_FC00);
    `CHK("store3", 10'h387, cr)
    chk_op(TEATTR_KIND_FETCH, 6'h03, 32'hFF00_0000);
    `CHK("fetch3", 3'b110, {cr.hit, cr.go, cr.little_end})
    chk_op(TEATTR_KIND_SPEC, 6'h03, 32'hFFFF_FC00);
    `CHK("spec3", 2'b01, {cr.go, cr.spec_block})
    chk_op(TEATTR_KIND_STORE, 6'h04, 32'h0000_03FC);
    `CHK("store4", 3'b101, {cr.hit, cr.go, cr.data_excp})
    `CHK("attr4", 2'b10, {cr.cacheable, cr.write_thru})
    chk_op(TEATTR_KIND_FETCH, 6'h04, 32'h0000_0000);
    `CHK("fetch4", 3'b101, {cr.hit, cr.go, cr.fetch_excp})
    chk_op(TEATTR_KIND_LOAD, 6'h04, 32'h0000_0400);
    `CHK("miss", 1'b0, cr.hit)
    @(negedge clk);
    `CHK("idle", 10'h000, cr)
  endtask
  task automatic t_zone();
    um = 1'b1;
    chk_op(TEATTR_KIND_LOAD, 6'h04, 32'h0);
    `CHK("deny", 2'b00, {cr.hit, cr.go})
    zone = 32'h0030_0000;
    chk_op(TEATTR_KIND_STORE, 6'h04, 32'h0);
    `CHK("grant", 3'b110, {cr.hit, cr.go, cr.data_excp})
    um = 1'b0;
    zone = 32'h0;
  endtask
  task automatic t_reset();
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    `CHK("rst tag", 8'h00, tag_val)
    sreg_op(1'b0, SEL_XLATE_LOW, 6'h03, 32'h0);
    `CHK("kept", 32'h0000_03FD, rsp.data)
    sreg_op(1'b0, SEL_XLATE_HIGH, 6'h03, 32'h0);
    `CHK("kept owner", 8'hAB, tag_val)
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    cfg = 1'b0;
    t_regs();
    t_perm();
    t_zone();
    t_reset();
    end_of_test();
  end
endmodule // teattr_tb
bind teattr_top teattr_asserts #(.DEFAULT_LITTLE(DEFAULT_LITTLE)) i_asserts (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cfg_load(i_cfg_load), .i_user_mode(i_user_mode),
  .i_sreg(i_sreg), .i_proc_tag(i_proc_tag), .i_zone_override(i_zone_override),
  .i_xlate_index(i_xlate_index), .i_chk(i_chk), .o_sreg_rsp(o_sreg_rsp),
  .o_proc_tag_load(o_proc_tag_load), .o_proc_tag_val(o_proc_tag_val), .o_chk_rsp(o_chk_rsp));
